//--- rtl/cma_arbitration.sv
// The AXI4-Lite register port was left to the implementer.
`timescale 1ns/1ps
// Overview of operation
// R1: object-valid low: handler ignores the object
// R2: object-valid high: object takes part in traffic
// R3: software invalidates unused objects before releasing init
// R4: software invalidates object before changing its setup
// R5: extended-select picks 11-bit or 29-bit identifier
// R6: receive object sends remote frame on request
// R7: matching data frame stored into receive object
// R8: transmit object sends data frame on request
// R9: matching remote frame sets request if answer enabled
// R10: upper register field layout, bits 31:16 reserved
// R11: standard objects compare identifier bits 28..18 only
// R12: two register copies at 0x34 and 0x94
// R13: identifier bits 15..0 in lower register
// R14: software programs masks before setting object-valid
// R15: reserved bits read zero, writes ignored
module cma_arbitration (
	// clock and reset
	input  wire logic                clk_sys,
	input  wire logic                rst,
	// axi4-lite write address
	input  wire logic                s_axi_awvalid,
	output logic                     s_axi_awready,
	input  wire logic [7:0]          s_axi_awaddr,
	// axi4-lite write data
	input  wire logic                s_axi_wvalid,
	output logic                     s_axi_wready,
	input  wire logic [31:0]         s_axi_wdata,
	input  wire logic [3:0]          s_axi_wstrb,
	// axi4-lite write response
	output logic                     s_axi_bvalid,
	input  wire logic                s_axi_bready,
	output logic [1:0]               s_axi_bresp,
	// axi4-lite read address
	input  wire logic                s_axi_arvalid,
	output logic                     s_axi_arready,
	input  wire logic [7:0]          s_axi_araddr,
	// axi4-lite read data
	output logic                     s_axi_rvalid,
	input  wire logic                s_axi_rready,
	output logic [31:0]              s_axi_rdata,
	output logic [1:0]               s_axi_rresp,
	// received frames from the protocol engine
	input  wire logic                rx_valid,
	input  wire cma_pkg::cma_frame_s rx_frame,
	output logic [1:0]               rx_stored,
	// frames to the protocol engine
	output logic                     tx_valid,
	output cma_pkg::cma_frame_s      tx_frame,
	input  wire logic                tx_ready
);

	// {hit, set, kind}
	function automatic logic [3:0] decode(input logic [7:0] a);
		unique case ({a[7:2], 2'h0})
			cma_pkg::OFF_IF1_LO:  decode = {2'h2, cma_pkg::KIND_LO};
			cma_pkg::OFF_IF1_UP:  decode = {2'h2, cma_pkg::KIND_UP};
			cma_pkg::OFF_IF1_CTL: decode = {2'h2, cma_pkg::KIND_CTL};
			cma_pkg::OFF_IF2_LO:  decode = {2'h3, cma_pkg::KIND_LO};
			cma_pkg::OFF_IF2_UP:  decode = {2'h3, cma_pkg::KIND_UP};
			cma_pkg::OFF_IF2_CTL: decode = {2'h3, cma_pkg::KIND_CTL};
			default:              decode = 4'h0;
		endcase
	endfunction

	// lanes 2 and 3 only ever carry reserved bits
	function automatic logic [15:0] merge(input logic [15:0] old,
		input logic [15:0] data, input logic [1:0] strb);
		merge = old;
		if (strb[0]) begin
			merge[7:0] = data[7:0];
		end
		if (strb[1]) begin
			merge[15:8] = data[15:8];
		end
	endfunction

	// register file, one entry per interface set
	logic [15:0]        lo_q   [2];
	logic [15:0]        lo_d   [2];
	logic [15:0]        up_q   [2];
	logic [15:0]        up_d   [2];
	logic [1:0]         ctl_q  [2];
	logic [1:0]         ctl_d  [2];
	logic [1:0]         rx_stored_q, rx_stored_d;

	// bus handshake state
	logic               aw_held_q, aw_held_d;
	logic [7:0]         aw_addr_q, aw_addr_d;
	logic               w_held_q, w_held_d;
	logic [31:0]        w_data_q, w_data_d;
	logic [3:0]         w_strb_q, w_strb_d;
	logic               bvalid_q, bvalid_d;
	logic [1:0]         bresp_q, bresp_d;
	logic               rvalid_q, rvalid_d;
	logic [31:0]        rdata_q, rdata_d;
	logic [1:0]         rresp_q, rresp_d;

	cma_pkg::cma_obj_s  obj    [2];
	logic [1:0]         store;
	logic [1:0]         answer;
	logic [1:0]         tx_done;
	logic               wr_go;
	logic [3:0]         wr_dec;
	logic [3:0]         rd_dec;

	for (genvar g = 0; g < cma_pkg::NUM_SETS; g++) begin : g_set
		assign obj[g].valid     = up_q[g][cma_pkg::UP_VALID]; // [R10]
		assign obj[g].extended  = up_q[g][cma_pkg::UP_XTD]; // [R10]
		assign obj[g].direction = up_q[g][cma_pkg::UP_DIR]; // [R10]
		assign obj[g].id        = {up_q[g][cma_pkg::UP_ID_MSB:0],
			lo_q[g]}; // [R10] [R13]
		assign obj[g].remote_en = ctl_q[g][1];
		assign obj[g].tx_req    = ctl_q[g][0];

		// both sets see every frame and decide on their own
		cma_obj_filter u_filter (
			.obj      (obj[g]),
			.rx_valid (rx_valid),
			.rx_frame (rx_frame),
			.store    (store[g]),
			.answer   (answer[g])
		);
	end

	// set 0 wins when both sets ask in the same cycle
	cma_tx_sel u_tx_sel (
		.clk_sys  (clk_sys),
		.rst      (rst),
		.obj0     (obj[0]),
		.obj1     (obj[1]),
		.tx_valid (tx_valid),
		.tx_frame (tx_frame),
		.tx_ready (tx_ready),
		.tx_done  (tx_done)
	);

	// no new write while a response still waits, so bresp never
	// changes under a stalled master
	assign wr_go  = aw_held_q && w_held_q && !bvalid_q;
	assign wr_dec = decode(aw_addr_q);
	assign rd_dec = decode(s_axi_araddr);

	// bus channels: address and data may arrive in either order
	always_comb begin
		aw_held_d = aw_held_q;
		aw_addr_d = aw_addr_q;
		w_held_d  = w_held_q;
		w_data_d  = w_data_q;
		w_strb_d  = w_strb_q;
		bvalid_d  = bvalid_q;
		bresp_d   = bresp_q;
		rvalid_d  = rvalid_q;
		rdata_d   = rdata_q;
		rresp_d   = rresp_q;
		if (s_axi_awvalid && s_axi_awready) begin
			aw_held_d = 1'b1;
			aw_addr_d = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			w_held_d = 1'b1;
			w_data_d = s_axi_wdata;
			w_strb_d = s_axi_wstrb;
		end
		if (wr_go) begin
			aw_held_d = 1'b0;
			w_held_d  = 1'b0;
			bvalid_d  = 1'b1;
			bresp_d   = wr_dec[3] ? cma_pkg::RESP_OKAY :
				cma_pkg::RESP_SLVERR;
		end else if (bvalid_q && s_axi_bready) begin
			bvalid_d = 1'b0;
		end
		if (s_axi_arvalid && s_axi_arready) begin
			rvalid_d = 1'b1;
			rdata_d  = 32'h0000_0000; // [R15]
			rresp_d  = rd_dec[3] ? cma_pkg::RESP_OKAY :
				cma_pkg::RESP_SLVERR;
			unique case (rd_dec[1:0])
				cma_pkg::KIND_LO:
					rdata_d[15:0] = lo_q[rd_dec[2]]; // [R13]
				cma_pkg::KIND_UP:
					rdata_d[15:0] = up_q[rd_dec[2]]; // [R10] [R12]
				// only the two implemented control bits show
				cma_pkg::KIND_CTL: begin
					rdata_d[cma_pkg::CTL_REMOTE_ANSWER_ENABLE] = ctl_q[rd_dec[2]][1];
					rdata_d[cma_pkg::CTL_TXRQ]  = ctl_q[rd_dec[2]][0];
				end
				default: rdata_d = 32'h0000_0000;
			endcase
			// unmapped reads give zero beside the error response
			if (!rd_dec[3]) begin
				rdata_d = 32'h0000_0000;
			end
		end else if (rvalid_q && s_axi_rready) begin
			rvalid_d = 1'b0;
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			aw_held_q <= 1'b0;
			aw_addr_q <= 8'h00;
			w_held_q  <= 1'b0;
			w_data_q  <= 32'h0000_0000;
			w_strb_q  <= 4'h0;
			bvalid_q  <= 1'b0;
			bresp_q   <= cma_pkg::RESP_OKAY;
			rvalid_q  <= 1'b0;
			rdata_q   <= 32'h0000_0000;
			rresp_q   <= cma_pkg::RESP_OKAY;
		end else begin
			aw_held_q <= aw_held_d;
			aw_addr_q <= aw_addr_d;
			w_held_q  <= w_held_d;
			w_data_q  <= w_data_d;
			w_strb_q  <= w_strb_d;
			bvalid_q  <= bvalid_d;
			bresp_q   <= bresp_d;
			rvalid_q  <= rvalid_d;
			rdata_q   <= rdata_d;
			rresp_q   <= rresp_d;
		end
	end

	// register file: completion clear, then software write, then remote answer and store on top
	always_comb begin
		for (int i = 0; i < 2; i++) begin
			lo_d[i]  = lo_q[i];
			up_d[i]  = up_q[i];
			ctl_d[i] = ctl_q[i];
			// completion clears first, so a software set in the
			// same cycle still wins and the request is not lost
			if (tx_done[i]) begin
				ctl_d[i][0] = 1'b0;
			end
		end
		// one registered pulse per set for each stored frame
		rx_stored_d = store;
		if (wr_go && wr_dec[3]) begin
			unique case (wr_dec[1:0])
				cma_pkg::KIND_LO:
					lo_d[wr_dec[2]] = merge(lo_q[wr_dec[2]],
						w_data_q[15:0], w_strb_q[1:0]); // [R13]
				// upper half is dropped, bits 31:16 hold nothing
				cma_pkg::KIND_UP:
					up_d[wr_dec[2]] = merge(up_q[wr_dec[2]],
						w_data_q[15:0], w_strb_q[1:0]); // [R10] [R12] [R15]
				cma_pkg::KIND_CTL: begin
					// both control bits sit in lane 1
					if (w_strb_q[1]) begin
						ctl_d[wr_dec[2]] = {w_data_q[cma_pkg::CTL_REMOTE_ANSWER_ENABLE],
							w_data_q[cma_pkg::CTL_TXRQ]};
					end
				end
				default: lo_d[0] = lo_q[0];
			endcase
		end
		for (int i = 0; i < 2; i++) begin
			// a remote answer beats a same-cycle software clear
			if (answer[i]) begin
				ctl_d[i][0] = 1'b1; // [R9]
			end
			// the stored identifier keeps the received bits
			if (store[i]) begin
				lo_d[i] = rx_frame.id[15:0]; // [R7] [R13]
				up_d[i][cma_pkg::UP_ID_MSB:0] =
					rx_frame.id[28:16]; // [R7]
			end
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			for (int i = 0; i < 2; i++) begin
				lo_q[i]  <= cma_pkg::RST_LO;
				up_q[i]  <= cma_pkg::RST_UP; // [R12]
				ctl_q[i] <= cma_pkg::RST_CTL;
			end
			rx_stored_q <= 2'h0;
		end else begin
			for (int i = 0; i < 2; i++) begin
				lo_q[i]  <= lo_d[i];
				up_q[i]  <= up_d[i];
				ctl_q[i] <= ctl_d[i];
			end
			rx_stored_q <= rx_stored_d;
		end
	end

	assign s_axi_awready = !aw_held_q;
	assign s_axi_wready  = !w_held_q;
	assign s_axi_bvalid  = bvalid_q;
	assign s_axi_bresp   = bresp_q;
	// one read in flight: next address waits until rdata is taken
	assign s_axi_arready = !rvalid_q;
	assign s_axi_rvalid  = rvalid_q;
	assign s_axi_rdata   = rdata_q;
	assign s_axi_rresp   = rresp_q;
	assign rx_stored     = rx_stored_q;

endmodule

//--- rtl/cma_pkg.sv
package cma_pkg;

	localparam int          ADDR_W      = 8;
	localparam int          NUM_SETS    = 2;

	// register byte offsets, one aligned word each
	localparam logic [7:0]  OFF_IF1_LO  = 8'h30;
	localparam logic [7:0]  OFF_IF1_UP  = 8'h34;
	localparam logic [7:0]  OFF_IF1_CTL = 8'h38;
	localparam logic [7:0]  OFF_IF2_LO  = 8'h90;
	localparam logic [7:0]  OFF_IF2_UP  = 8'h94;
	localparam logic [7:0]  OFF_IF2_CTL = 8'h98;

	// arbitration upper register fields
	localparam int          UP_VALID    = 15;
	localparam int          UP_XTD      = 14;
	localparam int          UP_DIR      = 13;
	localparam int          UP_ID_MSB   = 12;
	// message control register fields
	localparam int          CTL_REMOTE_ANSWER_ENABLE   = 9;
	localparam int          CTL_TXRQ    = 8;
	// standard identifier occupies id[28:18]
	localparam int          STD_ID_LSB  = 18;

	localparam logic [15:0] RST_LO      = 16'h0000;
	localparam logic [15:0] RST_UP      = 16'h0000;
	localparam logic [1:0]  RST_CTL     = 2'h0;

	localparam logic [1:0]  RESP_OKAY   = 2'h0;
	localparam logic [1:0]  RESP_SLVERR = 2'h2;

	// register kinds inside one interface set
	localparam logic [1:0]  KIND_LO     = 2'h0;
	localparam logic [1:0]  KIND_UP     = 2'h1;
	localparam logic [1:0]  KIND_CTL    = 2'h2;

	typedef struct packed {
		logic        valid;
		logic        extended;
		logic        direction;
		logic [28:0] id;
		logic        remote_en;
		logic        tx_req;
	} cma_obj_s;

	typedef struct packed {
		logic        remote;
		logic        extended;
		logic [28:0] id;
	} cma_frame_s;

endpackage

//--- rtl/cma_obj_filter.sv
`timescale 1ns/1ps
module cma_obj_filter (
	// object configuration
	input  wire cma_pkg::cma_obj_s   obj,
	// received frame from the protocol engine
	input  wire logic                rx_valid,
	input  wire cma_pkg::cma_frame_s rx_frame,
	// decisions
	output logic                     store,
	output logic                     answer
);

	function automatic logic id_match(input cma_pkg::cma_obj_s o,
		input cma_pkg::cma_frame_s f);
		if (o.extended) begin
			id_match = f.extended && (f.id == o.id); // [R5] [R11]
		end else begin
			id_match = !f.extended &&
				(f.id[28:cma_pkg::STD_ID_LSB] ==
				o.id[28:cma_pkg::STD_ID_LSB]); // [R5] [R11]
		end
	endfunction

	logic hit;

	// invalid objects never hit, so they see no traffic at all
	assign hit    = rx_valid && obj.valid && id_match(obj, rx_frame); // [R1] [R2]
	assign store  = hit && !obj.direction && !rx_frame.remote; // [R7]
	assign answer = hit && obj.direction && rx_frame.remote &&
		obj.remote_en; // [R9]

endmodule

//--- rtl/cma_tx_sel.sv
`timescale 1ns/1ps
module cma_tx_sel (
	// clock and reset
	input  wire logic                clk_sys,
	input  wire logic                rst,
	// objects of both interface sets
	input  wire cma_pkg::cma_obj_s   obj0,
	input  wire cma_pkg::cma_obj_s   obj1,
	// frame towards the protocol engine
	output logic                     tx_valid,
	output cma_pkg::cma_frame_s      tx_frame,
	input  wire logic                tx_ready,
	// one-cycle pulse per set when its frame is taken
	output logic [1:0]               tx_done
);

	typedef enum logic {
		TX_IDLE = 1'b0,
		TX_BUSY = 1'b1
	} cma_tx_e;

	cma_tx_e             state_q, state_d;
	logic                sel_q, sel_d;
	cma_pkg::cma_frame_s frame_q, frame_d;
	logic                want0, want1;
	cma_pkg::cma_obj_s   pick;

	assign want0 = obj0.valid && obj0.tx_req; // [R1] [R2]
	assign want1 = obj1.valid && obj1.tx_req; // [R1] [R2]
	assign pick  = want0 ? obj0 : obj1;

	always_comb begin
		state_d = state_q;
		sel_d   = sel_q;
		frame_d = frame_q;
		tx_done = 2'h0;
		unique case (state_q)
			TX_IDLE: begin
				if (want0 || want1) begin
					state_d         = TX_BUSY;
					sel_d           = !want0;
					// receive objects ask for their own data remotely
					frame_d.remote   = !pick.direction; // [R6] [R8]
					frame_d.extended = pick.extended; // [R5]
					frame_d.id       = pick.extended ? pick.id :
						{pick.id[28:cma_pkg::STD_ID_LSB],
						18'h00000}; // [R11]
				end
			end
			TX_BUSY: begin
				if (tx_ready) begin
					state_d        = TX_IDLE;
					tx_done[sel_q] = 1'b1;
				end
			end
		endcase
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			state_q <= TX_IDLE;
			sel_q   <= 1'b0;
			frame_q <= '0;
		end else begin
			state_q <= state_d;
			sel_q   <= sel_d;
			frame_q <= frame_d;
		end
	end

	assign tx_valid = (state_q == TX_BUSY);
	assign tx_frame = frame_q;

endmodule

//--- test/cma_arbitration_asserts.sv
`timescale 1ns/1ps
module cma_arbitration_asserts (
	// clock and reset
	input  wire logic                clk_sys,
	input  wire logic                rst,
	// register bus
	input  wire logic                s_axi_bvalid,
	input  wire logic                s_axi_bready,
	input  wire logic [1:0]          s_axi_bresp,
	input  wire logic                s_axi_arvalid,
	input  wire logic                s_axi_arready,
	input  wire logic                s_axi_rvalid,
	input  wire logic                s_axi_rready,
	input  wire logic [31:0]         s_axi_rdata,
	// frame side
	input  wire logic                rx_valid,
	input  wire cma_pkg::cma_frame_s rx_frame,
	input  wire logic [1:0]          rx_stored,
	input  wire logic                tx_valid,
	input  wire cma_pkg::cma_frame_s tx_frame,
	input  wire logic                tx_ready
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);
	a_resp_hold: assert property (
		s_axi_bvalid && !s_axi_bready |=>
		s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp dropped");
	a_read_answer: assert property (
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read not answered");
	a_read_hold: assert property (
		s_axi_rvalid && !s_axi_rready |=>
		s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata dropped");
	a_rsvd_zero: assert property (
		s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000)
		else $error("reserved bits set");
	a_tx_hold: assert property (
		tx_valid && !tx_ready |=> tx_valid && $stable(tx_frame))
		else $error("tx frame dropped");
	a_tx_release: assert property (
		tx_valid && tx_ready |=> !tx_valid) else $error("tx not released");
	a_std_zero: assert property (
		tx_valid && !tx_frame.extended |-> tx_frame.id[17:0] == 18'h00000)
		else $error("standard id low bits set");
	a_store_cause: assert property (
		rx_stored != 2'h0 |-> $past(rx_valid) && !$past(rx_frame.remote))
		else $error("store without data frame");
	a_remote_keep: assert property (
		rx_valid && rx_frame.remote |=> rx_stored == 2'h0)
		else $error("remote frame stored");
endmodule

bind cma_arbitration cma_arbitration_asserts cma_arbitration_asserts_i (
	.clk_sys, .rst, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
	.s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready,
	.s_axi_rdata, .rx_valid, .rx_frame, .rx_stored, .tx_valid,
	.tx_frame, .tx_ready
);

//--- test/cma_engine_model.sv
`timescale 1ns/1ps
module cma_engine_model (
	// clock
	input  wire logic                clk_sys,
	// frames from the block
	input  wire logic                tx_valid,
	input  wire cma_pkg::cma_frame_s tx_frame,
	output logic                     tx_ready,
	// frames into the block
	output logic                     rx_valid,
	output cma_pkg::cma_frame_s      rx_frame
);
	int                  stall = 0;
	int                  wait_c = 0;
	int                  n_tx = 0;
	cma_pkg::cma_frame_s got;
	initial begin
		tx_ready = 1'b0;
		rx_valid = 1'b0;
		rx_frame = '0;
	end
	// stall cycles before accepting, to exercise the hold
	always @(posedge clk_sys) begin
		if (tx_valid && tx_ready) begin
			got <= tx_frame;
			n_tx <= n_tx + 1;
			tx_ready <= 1'b0;
			wait_c <= 0;
		end else if (tx_valid && wait_c >= stall)
			tx_ready <= 1'b1;
		else if (tx_valid)
			wait_c <= wait_c + 1;
	end
	// one-cycle frame pulse, bus scrambled afterwards
	task send(input cma_pkg::cma_frame_s f);
		@(posedge clk_sys);
		rx_valid <= 1'b1;
		rx_frame <= f;
		@(posedge clk_sys);
		rx_valid <= 1'b0;
		rx_frame <= ~f;
	endtask
endmodule

//--- test/test_cma_arbitration.sv
`timescale 1ns/1ps
module test_cma_arbitration;
	logic clk_sys, rst, awvalid, wvalid, bready, arvalid, rready;
	logic awready, wready, bvalid, arready, rvalid, rx_valid, tx_valid;
	logic tx_ready;
	logic [7:0]  awaddr, araddr;
	logic [31:0] wdata, rdata, d;
	logic [3:0]  wstrb;
	logic [1:0]  bresp, rresp, rx_stored, r;
	cma_pkg::cma_frame_s rx_frame, tx_frame;
	int failures = 0;
	int n_compared = 0;
	int cyc = 0;
	int n0;
	logic [73:0] rows [4] = '{
		{8'h34, 32'hFFFF_FFFF, 32'h0000_FFFF, 2'h0},
		{8'h94, 32'h0000_A5A5, 32'h0000_A5A5, 2'h0},
		{8'h30, 32'h1234_5678, 32'h0000_5678, 2'h0},
		{8'h40, 32'h0000_1234, 32'h0000_0000, 2'h2}};
	cma_arbitration cma_arbitration_i (.clk_sys(clk_sys), .rst(rst),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_awaddr(awaddr), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_bresp(bresp),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_araddr(araddr), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.rx_valid(rx_valid), .rx_frame(rx_frame), .rx_stored(rx_stored),
		.tx_valid(tx_valid), .tx_frame(tx_frame), .tx_ready(tx_ready));
	cma_engine_model cma_engine_model_i (.clk_sys(clk_sys),
		.tx_valid(tx_valid), .tx_frame(tx_frame), .tx_ready(tx_ready),
		.rx_valid(rx_valid), .rx_frame(rx_frame));
	initial begin
		clk_sys = 1'b0;
		forever #50 clk_sys = ~clk_sys;
	end
	task complete_run;
		$display("compared %0d, failures %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 3000) begin
			failures++;
			complete_run;
		end
	end
	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			failures++;
			$display("Error at %0t: got %h, expected %h", $time, got, exp);
		end
	endtask
	task wr(input logic [7:0] a, input logic [31:0] v);
		logic aw, w;
		@(posedge clk_sys);
		awvalid <= 1'b1;
		awaddr <= a;
		wvalid <= 1'b1;
		wdata <= v;
		aw = 1'b1;
		w = 1'b1;
		while (aw || w) begin
			@(posedge clk_sys);
			if (aw && awready === 1'b1) begin
				aw = 1'b0;
				awvalid <= 1'b0;
			end
			if (w && wready === 1'b1) begin
				w = 1'b0;
				wvalid <= 1'b0;
			end
		end
		bready <= 1'b1;
		do @(posedge clk_sys); while (bvalid !== 1'b1);
		r = bresp;
		bready <= 1'b0;
	endtask
	task rd(input logic [7:0] a);
		@(posedge clk_sys);
		arvalid <= 1'b1;
		araddr <= a;
		do @(posedge clk_sys); while (arready !== 1'b1);
		arvalid <= 1'b0;
		rready <= 1'b1;
		do @(posedge clk_sys); while (rvalid !== 1'b1);
		d = rdata;
		r = rresp;
		rready <= 1'b0;
	endtask
	task tx_exp(input logic [30:0] f);
		while (cma_engine_model_i.n_tx == n0) @(posedge clk_sys);
		chk({1'b0, cma_engine_model_i.got}, {1'b0, f});
		n0 = cma_engine_model_i.n_tx;
	endtask
	task no_tx;
		repeat (6) @(posedge clk_sys);
		chk(cma_engine_model_i.n_tx, n0);
	endtask
	initial begin
		{awvalid, wvalid, bready, arvalid, rready} = '0;
		{awaddr, araddr, wdata} = '0;
		wstrb = 4'hF;
		rst = 1'b1;
		n0 = 0;
		repeat (20) @(posedge clk_sys);
		rst <= 1'b0;
		rd(8'h34);
		chk(d, 32'h0);
		rd(8'h94);
		chk(d, 32'h0);
		for (int i = 0; i < 4; i++) begin
			wr(rows[i][73:66], rows[i][65:34]);
			chk(r, rows[i][1:0]);
			rd(rows[i][73:66]);
			chk(d, rows[i][33:2]);
			chk({30'h0, r}, {30'h0, rows[i][1:0]});
		end
		rd(8'h34);
		chk(d, 32'h0000_FFFF);
		wstrb <= 4'h1;
		wr(8'h34, 32'h0000_1234);
		wstrb <= 4'hF;
		rd(8'h34);
		chk(d, 32'h0000_FF34);
		$display("register tests done");
		// invalid first, setup changed only while invalid
		wr(8'h34, 32'h0000_2123);
		wr(8'h38, 32'h0000_0100);
		no_tx;
		cma_engine_model_i.stall = 3;
		wr(8'h34, 32'h0000_A123);
		tx_exp({2'b00, 29'h0120_0000});
		rd(8'h38);
		chk(d, 32'h0);
		wr(8'h38, 32'h0000_0200);
		cma_engine_model_i.send({2'b10, 29'h0123_FFFF});
		tx_exp({2'b00, 29'h0120_0000});
		wr(8'h38, 32'h0);
		cma_engine_model_i.send({2'b10, 29'h0120_0000});
		no_tx;
		$display("transmit tests done");
		wr(8'h94, 32'h0); // no mask in use, valid set last
		wr(8'h90, 32'h0000_1111);
		wr(8'h94, 32'h0000_CABC);
		cma_engine_model_i.send({2'b01, 29'h0ABC_1111});
		#1 chk(rx_stored, 2'b10);
		cma_engine_model_i.send({2'b01, 29'h0ABC_2222});
		#1 chk(rx_stored, 2'b00);
		cma_engine_model_i.send({2'b00, 29'h0ABC_1111});
		#1 chk(rx_stored, 2'b00);
		cma_engine_model_i.send({2'b11, 29'h0ABC_1111});
		#1 chk(rx_stored, 2'b00);
		wr(8'h98, 32'h0000_0100);
		tx_exp({2'b11, 29'h0ABC_1111});
		$display("receive tests done");
		rst <= 1'b1;
		repeat (2) @(posedge clk_sys);
		rst <= 1'b0;
		rd(8'h90);
		chk(d, 32'h0);
		rd(8'h94);
		chk(d, 32'h0);
		$display("reset tests done");
		complete_run;
	end
endmodule
